/* hdl/lnc_pkg.sv */
package lnc_pkg;
  // ===========================================================
  // indirect register indices
  localparam logic [7:0] ADDR_DATA_FIRST = 8'h00;
  localparam logic [7:0] ADDR_DATA_LAST = 8'h07;
  localparam logic [7:0] ADDR_NODE_COMMAND = 8'h08;
  localparam logic [7:0] ADDR_NODE_STATE_FLAGS = 8'h09;
  localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h0a;
  localparam logic [7:0] ADDR_FRAME_LENGTH_CHECKSUM = 8'h0b;
  localparam logic [7:0] ADDR_BIT_RATE_DIVIDER_LOW = 8'h0c;
  localparam logic [7:0] ADDR_BIT_RATE_SCALE = 8'h0d;
  localparam logic [7:0] ADDR_FRAME_IDENTIFIER = 8'h0e;
  // ===========================================================
  // command and status bit positions
  localparam int CMD_HALT = 7;
  localparam int CMD_SLEEP_WARN = 6;
  localparam int CMD_FRAME_DIRECTION = 5;
  localparam int CMD_DATA_ACK = 4;
  localparam int CMD_INT_CLEAR = 3;
  localparam int CMD_FAULT_CLEAR = 2;
  localparam int CMD_WAKE_REQ = 1;
  localparam int CMD_START_REQ = 0;
  localparam int ST_ACTIVE = 7;
  localparam int ST_IDLE_TIMEOUT = 6;
  localparam int ST_ABORT = 5;
  localparam int ST_ID_RECEIVED = 4;
  localparam int ST_INT_PENDING = 3;
  localparam int ST_ERROR = 2;
  localparam int ST_WAKEUP = 1;
  localparam int ST_DONE = 0;
  localparam int SIZE_CHECKSUM_SELECT = 7;
  localparam logic [3:0] SIZE_FROM_ID = 4'hf;
  localparam logic [3:0] SIZE_MAX_DIRECT = 4'h8;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] FAULT_USED_MASK = 8'h1f;
  localparam logic [7:0] SIZE_USED_MASK = 8'h8f;
  localparam logic [7:0] ID_USED_MASK = 8'h3f;
  // ===========================================================
  // timing
  localparam longint CLK_HZ = 100_000_000;
  localparam longint IDLE_TIMEOUT_S = 4;
  localparam longint IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_S * CLK_HZ;

  typedef struct packed {
    logic [7:0] data;
    logic [2:0] index;
  } lnc_byte_t;

  typedef struct packed {
    logic sync_break;
    logic id_received;
    logic frame_done;
    logic [4:0] fault;
    logic wake_received;
    logic wake_sent;
    logic bus_activity;
  } lnc_engine_evt_t;
endpackage

/* hdl/lnc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module lnc_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic do_wr;
  logic do_rd;
  assign o_in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign o_out_valid = wr_ptr != rd_ptr;
  assign do_wr = i_in_valid && o_in_ready;
  assign do_rd = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge i_mclk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* hdl/lnc_node.sv */
`timescale 1ns/1ps
`default_nettype none
module lnc_node #(
  parameter longint IDLE_CYCLES = lnc_pkg::IDLE_TIMEOUT_CYC,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  // host indirect port
  input wire logic i_ptr_wr,
  input wire logic i_win_wr,
  input wire logic i_win_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_ptr,
  output logic [7:0] o_rdata,
  // mode strap from the configuration register outside
  input wire logic i_master_mode,
  // frame engine side
  input wire logic i_bus_active,
  input wire logic i_sync_break,
  input wire logic i_id_received,
  input wire logic i_frame_done,
  input wire logic [4:0] i_fault,
  input wire logic i_wake_received,
  input wire logic i_wake_sent,
  input wire logic i_rx_valid,
  output logic o_rx_ready,
  input wire logic [10:0] i_rx_byte,
  output logic o_start,
  output logic o_wake_tx,
  output logic o_halted,
  output logic o_frame_direction,
  output logic o_checksum_select,
  output logic [3:0] o_frame_bytes,
  output logic [5:0] o_frame_identifier,
  output logic [8:0] o_bit_rate_divider,
  output logic [7:0] o_bit_rate_scale,
  output logic o_irq
);
  // the idle counter is 40 bits wide; a whole frame must fit the fifo
  if (IDLE_CYCLES < 1 || IDLE_CYCLES > 64'h00ff_ffff_ffff) begin : g_bad_idle
    $error("idle timeout must be 1 to 2**40-1 cycles");
  end
  if (FIFO_DEPTH < 8) begin : g_bad_depth
    $error("receive fifo must hold eight bytes");
  end
  // ===========================================================
  // synchroniser for the engine-side bus activity level
  logic [1:0] act_sync;
  logic bus_active;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) act_sync <= 2'b00;
    else act_sync <= {act_sync[0], i_bus_active};
  end
  assign bus_active = act_sync[1];

  // ===========================================================
  // registers
  logic [7:0] data_buf [8];
  logic sleep_warn;
  logic frame_direction;
  logic data_ack;
  logic wake_req;
  logic start_req;
  logic halted;
  logic idle_timeout;
  logic abort_flag;
  logic id_received;
  logic int_pending;
  logic wake_flag;
  logic done_flag;
  logic [4:0] fault_flags;
  logic [7:0] frame_length_checksum;
  logic [7:0] bit_rate_divider_low;
  logic [7:0] bit_rate_scale;
  logic [7:0] frame_identifier;
  logic [7:0] ptr;
  logic in_frame;
  logic [39:0] idle_cnt;

  logic slave;
  logic cmd_wr;
  logic [7:0] wd;
  logic fault_any;
  logic err_flag;
  logic halt_cmd;
  logic int_clr;
  logic fault_clr;
  logic evt_done;
  logic evt_idle;
  logic evt_break;
  logic evt_id;
  logic evt_wake;
  logic lnc_byte_ok;
  lnc_pkg::lnc_byte_t rx_word;

  assign slave = !i_master_mode;
  assign cmd_wr = i_win_wr && ptr == lnc_pkg::ADDR_NODE_COMMAND;
  assign wd = i_wdata;
  assign halt_cmd = cmd_wr && slave && wd[lnc_pkg::CMD_HALT];
  assign int_clr = cmd_wr && wd[lnc_pkg::CMD_INT_CLEAR];
  assign fault_clr = cmd_wr && wd[lnc_pkg::CMD_FAULT_CLEAR];
  assign fault_any = |(i_fault & {slave, slave, 3'b111});
  // identifier and done events are ignored while halted; the break that ends it and wake events still pass
  assign evt_break = i_sync_break;
  assign evt_id = i_id_received && !halted && slave;
  assign evt_done = i_frame_done && !halted;
  assign evt_wake = i_wake_received;
  assign evt_idle = slave && !sleep_warn && idle_cnt == 40'(IDLE_CYCLES - 1) && !idle_timeout;
  assign err_flag = |fault_flags;

  // ===========================================================
  // indirect pointer
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) ptr <= lnc_pkg::RESET_BYTE;
    else if (i_ptr_wr) ptr <= i_wdata;
  end
  assign o_ptr = ptr;

  // ===========================================================
  // data buffer: host writes, or received bytes drained from the fifo
  logic fifo_valid;
  logic [10:0] fifo_data;
  // host writes to the buffer win; the fifo waits so no byte is lost
  logic host_buf_wr;
  assign host_buf_wr = i_win_wr && ptr <= lnc_pkg::ADDR_DATA_LAST;
  assign lnc_byte_ok = fifo_valid && !host_buf_wr;
  assign rx_word = fifo_data;

  lnc_fifo #(
    .WIDTH(11),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_in_valid(i_rx_valid),
    .o_in_ready(o_rx_ready),
    .i_in_data(i_rx_byte),
    .o_out_valid(fifo_valid),
    .i_out_ready(!host_buf_wr),
    .o_out_data(fifo_data)
  );

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < 8; i++) data_buf[i] <= lnc_pkg::RESET_BYTE;
    end else if (host_buf_wr) begin
      data_buf[ptr[2:0]] <= i_wdata;
    end else if (lnc_byte_ok) begin
      data_buf[rx_word.index] <= rx_word.data;
    end
  end

  // ===========================================================
  // configuration registers
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      frame_length_checksum <= lnc_pkg::RESET_BYTE;
      bit_rate_divider_low <= lnc_pkg::RESET_BYTE;
      bit_rate_scale <= lnc_pkg::RESET_BYTE;
      frame_identifier <= lnc_pkg::RESET_BYTE;
    end else if (i_win_wr) begin
      unique case (ptr)
        lnc_pkg::ADDR_FRAME_LENGTH_CHECKSUM:
          frame_length_checksum <= i_wdata & lnc_pkg::SIZE_USED_MASK;
        lnc_pkg::ADDR_BIT_RATE_DIVIDER_LOW: bit_rate_divider_low <= i_wdata;
        lnc_pkg::ADDR_BIT_RATE_SCALE: bit_rate_scale <= i_wdata;
        lnc_pkg::ADDR_FRAME_IDENTIFIER: frame_identifier <= i_wdata & lnc_pkg::ID_USED_MASK;
        default: ;
      endcase
    end
  end

  // ===========================================================
  // command bits
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sleep_warn <= 1'b0;
      frame_direction <= 1'b0;
    end else if (cmd_wr) begin
      sleep_warn <= slave && wd[lnc_pkg::CMD_SLEEP_WARN];
      frame_direction <= wd[lnc_pkg::CMD_FRAME_DIRECTION];
    end
  end

  // acknowledge is a one-cycle strobe that clears id_received, then clears itself
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) data_ack <= 1'b0;
    else data_ack <= cmd_wr && slave && wd[lnc_pkg::CMD_DATA_ACK];
  end

  // a wake request is refused while an error is pending
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) wake_req <= 1'b0;
    else if (cmd_wr && wd[lnc_pkg::CMD_WAKE_REQ] && !err_flag) wake_req <= 1'b1;
    else if (i_wake_sent || fault_any) wake_req <= 1'b0;
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) start_req <= 1'b0;
    else if (cmd_wr && i_master_mode && wd[lnc_pkg::CMD_START_REQ] && !err_flag)
      start_req <= 1'b1;
    else if (i_frame_done || fault_any) start_req <= 1'b0;
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) halted <= 1'b0;
    else if (halt_cmd) halted <= 1'b1;
    else if (evt_break || !slave) halted <= 1'b0;
  end

  // ===========================================================
  // status flags
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) in_frame <= 1'b0;
    else if (evt_break && !halted) in_frame <= 1'b1;
    else if (i_frame_done || fault_any || halt_cmd) in_frame <= 1'b0;
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) abort_flag <= 1'b0;
    else if (!slave) abort_flag <= 1'b0;
    else if (halt_cmd || (evt_break && in_frame)) abort_flag <= 1'b1;
    else if (evt_break) abort_flag <= 1'b0;
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) id_received <= 1'b0;
    else if (evt_id) id_received <= 1'b1;
    else if (data_ack || halt_cmd || evt_break || !slave) id_received <= 1'b0;
  end

  // idle counter runs only while quiet; long count is a parameter
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) idle_cnt <= '0;
    else if (bus_active || sleep_warn || !slave) idle_cnt <= '0;
    else if (idle_cnt != 40'(IDLE_CYCLES - 1)) idle_cnt <= idle_cnt + 40'h1;
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) idle_timeout <= 1'b0;
    else if (evt_idle) idle_timeout <= 1'b1;
    else if (bus_active || sleep_warn || !slave) idle_timeout <= 1'b0;
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) fault_flags <= 5'h00;
    else begin
      // a fault arriving with the clear command still lands
      fault_flags <= (fault_clr ? 5'h00 : fault_flags) | (i_fault & {slave, slave, 3'b111});
    end
  end

  // wake status drops once the bus is busy again, no wake is queued and no sleep warning is set
  function automatic logic bus_back_after_wake();
    return bus_active && !wake_req;
  endfunction

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) wake_flag <= 1'b0;
    else if (wake_req || evt_wake) wake_flag <= 1'b1;
    else if (!sleep_warn && bus_back_after_wake()) wake_flag <= 1'b0;
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) done_flag <= 1'b0;
    else if (evt_done || evt_wake || (i_wake_sent && i_master_mode)) done_flag <= 1'b1;
    else if (o_start) done_flag <= 1'b0;
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) int_pending <= 1'b0;
    else if (evt_id || evt_done || fault_any || evt_idle || evt_wake) int_pending <= 1'b1;
    else if (int_clr) int_pending <= 1'b0;
  end

  // ===========================================================
  // length decode
  function automatic logic [3:0] frame_bytes(input logic [7:0] size, input logic [7:0] id);
    logic [3:0] n;
    n = 4'h0;
    if (size[3:0] == lnc_pkg::SIZE_FROM_ID) begin
      unique case (id[5:4])
        2'b00, 2'b01: n = 4'h2;
        2'b10: n = 4'h4;
        default: n = 4'h8;
      endcase
    end else if (size[3:0] <= lnc_pkg::SIZE_MAX_DIRECT) begin
      n = size[3:0];
    end
    return n;
  endfunction

  // ===========================================================
  // read mux; command bits marked write-only read as zero
  logic [7:0] state_flags;
  logic [7:0] cmd_view;
  always_comb begin
    state_flags = 8'h00;
    state_flags[lnc_pkg::ST_ACTIVE] = bus_active;
    state_flags[lnc_pkg::ST_IDLE_TIMEOUT] = idle_timeout;
    state_flags[lnc_pkg::ST_ABORT] = abort_flag;
    state_flags[lnc_pkg::ST_ID_RECEIVED] = id_received;
    state_flags[lnc_pkg::ST_INT_PENDING] = int_pending;
    state_flags[lnc_pkg::ST_ERROR] = err_flag;
    state_flags[lnc_pkg::ST_WAKEUP] = wake_flag;
    state_flags[lnc_pkg::ST_DONE] = done_flag;
    cmd_view = 8'h00;
    cmd_view[lnc_pkg::CMD_DATA_ACK] = data_ack;
    cmd_view[lnc_pkg::CMD_WAKE_REQ] = wake_req;
    cmd_view[lnc_pkg::CMD_START_REQ] = start_req;
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) o_rdata <= lnc_pkg::RESET_BYTE;
    else if (i_win_rd) begin
      if (ptr <= lnc_pkg::ADDR_DATA_LAST) o_rdata <= data_buf[ptr[2:0]];
      else begin
        unique case (ptr)
          lnc_pkg::ADDR_NODE_COMMAND: o_rdata <= cmd_view;
          lnc_pkg::ADDR_NODE_STATE_FLAGS: o_rdata <= state_flags;
          lnc_pkg::ADDR_FAULT_FLAGS: o_rdata <= {3'b000, fault_flags};
          lnc_pkg::ADDR_FRAME_LENGTH_CHECKSUM: o_rdata <= frame_length_checksum;
          lnc_pkg::ADDR_BIT_RATE_DIVIDER_LOW: o_rdata <= bit_rate_divider_low;
          lnc_pkg::ADDR_BIT_RATE_SCALE: o_rdata <= bit_rate_scale;
          lnc_pkg::ADDR_FRAME_IDENTIFIER: o_rdata <= frame_identifier;
          default: o_rdata <= lnc_pkg::RESET_BYTE;
        endcase
      end
    end
  end

  // ===========================================================
  // engine controls
  assign o_start = start_req && i_master_mode;
  assign o_wake_tx = wake_req;
  assign o_halted = halted;
  assign o_frame_direction = frame_direction;
  assign o_checksum_select = frame_length_checksum[lnc_pkg::SIZE_CHECKSUM_SELECT];
  assign o_frame_bytes = frame_bytes(frame_length_checksum, frame_identifier);
  assign o_frame_identifier = frame_identifier[5:0];
  assign o_bit_rate_divider = {bit_rate_scale[0], bit_rate_divider_low};
  assign o_bit_rate_scale = bit_rate_scale;
  assign o_irq = int_pending;
endmodule
`default_nettype wire

/* tb/lnc_node_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module lnc_node_sva (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_ptr_wr,
  input wire logic i_win_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_ptr,
  input wire logic i_master_mode,
  input wire logic i_sync_break,
  input wire logic i_id_received,
  input wire logic i_frame_done,
  input wire logic [4:0] i_fault,
  input wire logic i_wake_received,
  input wire logic i_wake_sent,
  input wire logic o_start,
  input wire logic o_wake_tx,
  input wire logic o_halted,
  input wire logic o_frame_direction,
  input wire logic o_checksum_select,
  input wire logic o_irq
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  logic cmd_wr;
  logic evt;
  assign cmd_wr = i_win_wr && o_ptr == lnc_pkg::ADDR_NODE_COMMAND;
  assign evt = i_id_received | i_frame_done | (|i_fault) | i_wake_received | i_wake_sent;
  // ==========================================================
  // command write sequences
  sequence s_cmd(int b);
    cmd_wr && i_wdata[b];
  endsequence
  sequence s_slave_cmd(int b);
    !i_master_mode ##0 s_cmd(b);
  endsequence
  // ==========================================================
  // properties
  ptr_load_a: assert property (i_ptr_wr |=> o_ptr == $past(i_wdata))
    else $error("pointer not loaded");
  dir_follow_a: assert property (cmd_wr |=> o_frame_direction == $past(i_wdata[5]))
    else $error("direction bit wrong");
  csum_select_a: assert property (i_win_wr && o_ptr == lnc_pkg::ADDR_FRAME_LENGTH_CHECKSUM
    |=> o_checksum_select == $past(i_wdata[7])) else $error("checksum select wrong");
  start_end_a: assert property (o_start && (i_frame_done || |i_fault[2:0]) && !cmd_wr
    |=> !o_start) else $error("start request not cleared");
  slave_start_a: assert property (!o_start ##0 s_slave_cmd(lnc_pkg::CMD_START_REQ)
    |=> !o_start) else $error("start taken in slave mode");
  wake_end_a: assert property (o_wake_tx && i_wake_sent && !cmd_wr |=> !o_wake_tx)
    else $error("wake request not cleared");
  halt_set_a: assert property (s_slave_cmd(lnc_pkg::CMD_HALT) ##0 !i_sync_break
    |=> o_halted) else $error("halt not taken");
  halt_hold_a: assert property (o_halted && !i_sync_break && !i_master_mode
    |=> o_halted) else $error("halt dropped early");
  irq_hold_a: assert property (o_irq && !(cmd_wr && i_wdata[lnc_pkg::CMD_INT_CLEAR])
    |=> o_irq) else $error("interrupt dropped early");
  irq_clear_a: assert property (i_master_mode ##0 s_cmd(lnc_pkg::CMD_INT_CLEAR) ##0 !evt
    |=> !o_irq) else $error("interrupt not cleared");
endmodule
bind lnc_node lnc_node_sva u_sva (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ptr_wr(i_ptr_wr),
  .i_win_wr(i_win_wr), .i_wdata(i_wdata), .o_ptr(o_ptr), .i_master_mode(i_master_mode),
  .i_sync_break(i_sync_break), .i_id_received(i_id_received), .i_frame_done(i_frame_done),
  .i_fault(i_fault), .i_wake_received(i_wake_received), .i_wake_sent(i_wake_sent),
  .o_start(o_start), .o_wake_tx(o_wake_tx), .o_halted(o_halted),
  .o_frame_direction(o_frame_direction), .o_checksum_select(o_checksum_select), .o_irq(o_irq));
`default_nettype wire

/* tb/lnc_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module lnc_peer (
  input wire logic i_mclk,
  input wire logic i_rx_ready,
  output var lnc_pkg::lnc_engine_evt_t o_evt,
  output logic o_rx_valid,
  output logic [10:0] o_rx_byte
);
  initial begin
    o_evt = '0;
    o_rx_valid = 1'b0;
    o_rx_byte = '0;
  end
  // ==========================================================
  // one-cycle event pulses; the bus activity level is kept
  task fire(input logic [10:0] e);
    @(posedge i_mclk);
    o_evt <= lnc_pkg::lnc_engine_evt_t'(e | {10'h000, o_evt.bus_activity});
    @(posedge i_mclk);
    o_evt <= lnc_pkg::lnc_engine_evt_t'({10'h000, o_evt.bus_activity});
    #1;
  endtask
  task level(input logic a);
    @(posedge i_mclk);
    o_evt.bus_activity <= a;
  endtask
  // ==========================================================
  // received byte, held until taken; a released line shows junk
  task send(input logic [10:0] b, input int gap);
    repeat (gap + 1) @(posedge i_mclk);
    o_rx_valid <= 1'b1;
    o_rx_byte <= b;
    do @(posedge i_mclk); while (!i_rx_ready);
    o_rx_valid <= 1'b0;
    o_rx_byte <= ~b;
  endtask
endmodule
`default_nettype wire

/* tb/lin_node_control_status_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module lin_node_control_status_bench;
  logic mclk = 1'b0;
  logic resetn, ptr_wr, win_wr, win_rd, master, rx_valid, rx_ready;
  logic start, wake_tx, halted, dir, csel, irq, refused;
  logic [7:0] wdata, ptr, rdata, scale;
  logic [15:0] got;
  logic [10:0] rx_byte;
  logic [3:0] nbytes;
  logic [5:0] fid;
  logic [8:0] div;
  lnc_pkg::lnc_engine_evt_t ev;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 46873;
  int f;
  int mem [16] = '{default: 0};
  int q [$];
  int sizes [4] = '{2, 2, 4, 8};
  always #5 mclk = ~mclk;
  lnc_node #(.IDLE_CYCLES(50), .FIFO_DEPTH(8)) uut (.i_mclk(mclk), .i_resetn(resetn),
    .i_ptr_wr(ptr_wr), .i_win_wr(win_wr), .i_win_rd(win_rd), .i_wdata(wdata), .o_ptr(ptr),
    .o_rdata(rdata), .i_master_mode(master), .i_bus_active(ev.bus_activity),
    .i_sync_break(ev.sync_break), .i_id_received(ev.id_received), .i_frame_done(ev.frame_done),
    .i_fault(ev.fault), .i_wake_received(ev.wake_received), .i_wake_sent(ev.wake_sent),
    .i_rx_valid(rx_valid), .o_rx_ready(rx_ready), .i_rx_byte(rx_byte), .o_start(start),
    .o_wake_tx(wake_tx), .o_halted(halted), .o_frame_direction(dir), .o_checksum_select(csel),
    .o_frame_bytes(nbytes), .o_frame_identifier(fid), .o_bit_rate_divider(div),
    .o_bit_rate_scale(scale), .o_irq(irq));
  lnc_peer peer (.i_mclk(mclk), .i_rx_ready(rx_ready), .o_evt(ev), .o_rx_valid(rx_valid),
    .o_rx_byte(rx_byte));
  // ==========================================================
  // host port tasks and comparison
  task chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task point(input logic [7:0] a);
    @(posedge mclk);
    ptr_wr <= 1'b1;
    wdata <= a;
    @(posedge mclk);
    ptr_wr <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    point(a);
    win_wr <= 1'b1;
    wdata <= d;
    @(posedge mclk);
    win_wr <= 1'b0;
    if (a < 8'h08 || a > 8'h0a) mem[a] = d & (a == 8'h0b ? lnc_pkg::SIZE_USED_MASK :
      a == 8'h0e ? lnc_pkg::ID_USED_MASK : 8'hff);
    #1;
  endtask
  task rd(input logic [7:0] a);
    point(a);
    win_rd <= 1'b1;
    @(posedge mclk);
    win_rd <= 1'b0;
    #1 got = 16'(rdata);
  endtask
  task mode(input logic m);
    @(posedge mclk);
    master <= m;
  endtask
  task finish_test;
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    {resetn, ptr_wr, win_wr, win_rd, master, refused} = '0;
    wdata = 8'h00;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    for (int a = 0; a < 15; a++) begin
      rd(8'(a));
      chk(got, 16'h0000);
    end
    for (int a = 0; a < 16; a++) if (a < 8 || a > 10) wr(8'(a), 8'($random(seed)));
    for (int a = 0; a < 15; a++) begin
      if (a < 8 || a > 10) begin
        rd(8'(a));
        chk(got, 16'(mem[a]));
      end
    end
    chk(16'(div), 16'({mem[13][0], mem[12][7:0]}));
    chk(16'(scale), 16'(mem[13]));
    chk(16'(fid), 16'(mem[14][5:0]));
    chk(16'(csel), 16'(mem[11][7]));
    for (int k = 0; k < 4; k++) begin
      wr(8'h0e, 8'(k << 4));
      wr(8'h0b, 8'h0f);
      chk(16'(nbytes), 16'(sizes[k]));
    end
    for (int n = 0; n < 9; n++) begin
      wr(8'h0b, 8'(n));
      chk(16'(nbytes), 16'(n));
    end
    // master frame, then a frame cut short by a bit error
    mode(1'b1);
    wr(8'h08, 8'h08);
    chk(16'(irq), 16'h0);
    wr(8'h08, 8'h21);
    chk(16'(start), 16'h1);
    chk(16'(dir), 16'h1);
    peer.fire(11'h100);
    chk(16'(start), 16'h0);
    chk(16'(irq), 16'h1);
    rd(8'h09);
    chk(got & 16'h0009, 16'h0009);
    wr(8'h08, 8'h08);
    chk(16'(irq), 16'h0);
    wr(8'h08, 8'h01);
    rd(8'h09);
    chk(got & 16'h0001, 16'h0000);
    peer.fire(11'h008);
    chk(16'(start), 16'h0);
    rd(8'h0a);
    chk(got, 16'h0001);
    wr(8'h08, 8'h03);
    chk(16'({start, wake_tx}), 16'h0);
    wr(8'h08, 8'h0c);
    rd(8'h0a);
    chk(got, 16'h0000);
    wr(8'h08, 8'h02);
    chk(16'(wake_tx), 16'h1);
    peer.fire(11'h002);
    chk(16'(wake_tx), 16'h0);
    rd(8'h09);
    chk(got & 16'h0006, 16'h0002);
    // slave: idle timeout, activity, identifier, halt and every fault code
    mode(1'b0);
    wr(8'h08, 8'h0d);
    chk(16'(start), 16'h0);
    repeat (60) @(posedge mclk);
    rd(8'h09);
    chk(got & 16'h0040, 16'h0040);
    wr(8'h08, 8'h40);
    peer.level(1'b1);
    rd(8'h09);
    chk(got & 16'h0080, 16'h0080);
    peer.fire(11'h200);
    rd(8'h09);
    chk(got & 16'h0010, 16'h0010);
    wr(8'h08, 8'h10);
    rd(8'h08);
    chk(got & 16'h009c, 16'h0000);
    wr(8'h08, 8'h80);
    chk(16'(halted), 16'h1);
    rd(8'h09);
    chk(got & 16'h0020, 16'h0020);
    peer.fire(11'h400);
    chk(16'(halted), 16'h0);
    rd(8'h09);
    chk(got & 16'h0020, 16'h0000);
    peer.fire(11'h400);
    peer.fire(11'h400);
    rd(8'h09);
    chk(got & 16'h0020, 16'h0020);
    for (int k = 0; k < 5; k++) begin
      f = (1 << k) | ($random(seed) & 31);
      peer.fire(11'(f << 3));
      rd(8'h0a);
      chk(got, 16'(f));
      wr(8'h08, 8'h04);
    end
    wr(8'h08, 8'h40);
    peer.fire(11'h004);
    rd(8'h09);
    chk(got & 16'h0002, 16'h0002);
    // a held buffer write stalls the drain so the fifo fills and refuses
    point(8'h07);
    win_wr <= 1'b1;
    wdata <= 8'h5a;
    mem[7] = 8'h5a;
    fork
      for (int i = 0; i < 8; i++) begin
        q.push_back($random(seed) & 255);
        peer.send({8'(q[i]), 3'(i)}, i % 3);
      end
      repeat (40) @(posedge mclk) if (!rx_ready) refused = 1'b1;
    join
    win_wr <= 1'b0;
    repeat (12) @(posedge mclk);
    chk(16'(refused), 16'h1);
    for (int i = 0; i < 8; i++) begin
      rd(8'(i));
      chk(got, 16'(q[i]));
    end
    finish_test();
  end
endmodule
`default_nettype wire
